// ==== verilog/ltmc_defs.vh ====
`ifndef LTMC_DEFS_VH
`define LTMC_DEFS_VH

// mode encodings
`define LTMC_ST_W          3
`define LTMC_ST_POR        3'h0
`define LTMC_ST_READY      3'h1
`define LTMC_ST_OPER       3'h2
`define LTMC_ST_TXOFF      3'h3
`define LTMC_ST_PDOWN      3'h4

// clock rate and times, in their own units
`define LTMC_CLK_MHZ       250
`define LTMC_DEGLITCH_US   20
`define LTMC_WAKE_FILT_US  80
`define LTMC_STAB_MIN_US   300
`define LTMC_DOM_TO_US     20000

// cycle counts derived from the times
`define LTMC_DEGLITCH_CYC  (`LTMC_DEGLITCH_US * `LTMC_CLK_MHZ)
`define LTMC_WAKE_FILT_CYC (`LTMC_WAKE_FILT_US * `LTMC_CLK_MHZ)
`define LTMC_STAB_MIN_CYC  (`LTMC_STAB_MIN_US * `LTMC_CLK_MHZ)
`define LTMC_DOM_TO_CYC    (`LTMC_DOM_TO_US * `LTMC_CLK_MHZ)

// widths
`define LTMC_CNT_W         24
`define LTMC_SYNC_W        9

// synchronised input bit positions
`define LTMC_IN_ON         0
`define LTMC_IN_OFF        1
`define LTMC_IN_RGOOD      2
`define LTMC_IN_THERM      3
`define LTMC_IN_SHORT      4
`define LTMC_IN_SEL        5
`define LTMC_IN_TXD        6
`define LTMC_IN_BUS        7
`define LTMC_IN_WAKELOW    8

// reset values of synchroniser stages (pins idle: select low, txd high, bus recessive)
`define LTMC_SYNC_RST      9'h0C0

`endif

// ==== verilog/ltmc_sync.v ====
`include "ltmc_defs.vh"

module ltmc_sync #(
    parameter                 WIDTH = `LTMC_SYNC_W,
    parameter [WIDTH-1:0]     RST_V = `LTMC_SYNC_RST
) (
    input  wire               clk_sys_i,
    input  wire               rst_i,
    input  wire [WIDTH-1:0]   async_i,
    output wire [WIDTH-1:0]   sync_o
);

    genvar g;
    generate
        for (g = 0; g < WIDTH; g = g + 1) begin : g_bit
            reg meta_r;
            reg stab_r;
            // first stage is read only by the second
            always @(posedge clk_sys_i or posedge rst_i) begin
                if (rst_i) begin
                    meta_r <= RST_V[g];
                    stab_r <= RST_V[g];
                end else begin
                    meta_r <= async_i[g];
                    stab_r <= meta_r;
                end
            end
            assign sync_o[g] = stab_r;
        end
    endgenerate

endmodule

// ==== verilog/ltmc_tmr.v ====
`include "ltmc_defs.vh"

module ltmc_tmr #(
    parameter                   W     = `LTMC_CNT_W,
    parameter [W-1:0]           LIMIT = `LTMC_DEGLITCH_CYC
) (
    input  wire                 clk_sys_i,
    input  wire                 rst_i,
    input  wire                 run_i,
    output reg                  done_o
);

    reg [W-1:0] cnt_r;

    // counts while run_i holds, clears at once when it drops; saturates at LIMIT
    always @(posedge clk_sys_i or posedge rst_i) begin
        if (rst_i) begin
            cnt_r  <= {W{1'b0}};
            done_o <= 1'b0;
        end else if (!run_i) begin
            cnt_r  <= {W{1'b0}};
            done_o <= 1'b0;
        end else if (cnt_r < LIMIT) begin
            cnt_r  <= cnt_r + {{(W-1){1'b0}}, 1'b1};
            done_o <= (cnt_r + {{(W-1){1'b0}}, 1'b1}) >= LIMIT;
        end else begin
            done_o <= 1'b1;
        end
    end

endmodule

// ==== verilog/ltmc_ctrl.v ====
// Summary of operation
// - low battery supply forces power-on reset
// - reset state: logic reset, phy off, reset low
// - leave reset only above turn-on threshold
// - low supply returns to reset from anywhere
// - ready: regulator reduced power, receiver on
// - stay ready until regulator stable, select high
// - select rise, good, txd high: operation
// - operation enables tx, rx, full-power regulator, no wake; pull-up only here
// - select fall or fault: transmitter off
// - faults: dominant, short, thermal, regulator bad
// - txd low at select fall: deglitched power-down
// - ready, select high, txd low: transmitter off
// - transmitter off: receiver on, regulator reduced
// - transmitter off while regulator unstable
// - transmitter off, both inputs low: power-down
// - power-down: only wake circuits stay active
// - power-down wake or select high: ready
// - wait regulator stabilisation before leaving ready
// - bus wake needs filtered low then rise
// - transmitter drives bus as txd dictates
// - long dominant: tx off, rxd recessive, pull-up off
// - reset output released while regulator valid
`include "ltmc_defs.vh"

module ltmc_ctrl #(
    parameter [`LTMC_CNT_W-1:0] DEGLITCH_CYC  = `LTMC_DEGLITCH_CYC,
    parameter [`LTMC_CNT_W-1:0] WAKE_FILT_CYC = `LTMC_WAKE_FILT_CYC,
    parameter [`LTMC_CNT_W-1:0] STAB_MIN_CYC  = `LTMC_STAB_MIN_CYC,
    parameter [`LTMC_CNT_W-1:0] DOM_TO_CYC    = `LTMC_DOM_TO_CYC
) (
    input  wire                  clk_sys_i,
    input  wire                  rst_i,
    input  wire                  supply_above_on_i,
    input  wire                  supply_below_off_i,
    input  wire                  regulator_good_i,
    input  wire                  thermal_fault_i,
    input  wire                  bus_short_fault_i,
    input  wire                  select_wake_input_i,
    input  wire                  txd_i,
    input  wire                  bus_line_i,
    input  wire                  bus_wake_low_i,
    output reg                   logic_rst_o,
    output reg                   tx_en_o,
    output reg                   rx_en_o,
    output reg                   reg_en_o,
    output reg                   reg_low_power_o,
    output reg                   pullup_en_o,
    output reg                   wake_en_o,
    output reg                   bus_line_o,
    output reg                   bus_line_oe_n_o,
    output reg                   rxd_o,
    output reg                   reset_o,
    output reg                   reset_oe_n_o,
    output reg  [`LTMC_ST_W-1:0] state_o
);

    // ------------------------------------------------------------
    // input synchronisation
    // ------------------------------------------------------------
    wire [`LTMC_SYNC_W-1:0] in_async;
    wire [`LTMC_SYNC_W-1:0] in_s;

    assign in_async = {bus_wake_low_i,
                       bus_line_i,
                       txd_i,
                       select_wake_input_i,
                       bus_short_fault_i,
                       thermal_fault_i,
                       regulator_good_i,
                       supply_below_off_i,
                       supply_above_on_i};

    ltmc_sync #(
        .WIDTH (`LTMC_SYNC_W),
        .RST_V (`LTMC_SYNC_RST)
    ) u_sync (
        .clk_sys_i (clk_sys_i),
        .rst_i     (rst_i),
        .async_i   (in_async),
        .sync_o    (in_s)
    );

    wire on_s;
    wire off_s;
    wire rgood_s;
    wire therm_s;
    wire short_s;
    wire sel_s;
    wire txd_s;
    wire bus_s;
    wire wlow_s;

    assign on_s    = in_s[`LTMC_IN_ON];
    assign off_s   = in_s[`LTMC_IN_OFF];
    assign rgood_s = in_s[`LTMC_IN_RGOOD];
    assign therm_s = in_s[`LTMC_IN_THERM];
    assign short_s = in_s[`LTMC_IN_SHORT];
    assign sel_s   = in_s[`LTMC_IN_SEL];
    assign txd_s   = in_s[`LTMC_IN_TXD];
    assign bus_s   = in_s[`LTMC_IN_BUS];
    assign wlow_s  = in_s[`LTMC_IN_WAKELOW];

    // ------------------------------------------------------------
    // edge detection on the synchronised select and wake levels
    // ------------------------------------------------------------
    reg sel_d_r;
    reg wlow_d_r;

    always @(posedge clk_sys_i or posedge rst_i) begin
        if (rst_i) begin
            sel_d_r  <= 1'b0;
            wlow_d_r <= 1'b0;
        end else begin
            sel_d_r  <= sel_s;
            wlow_d_r <= wlow_s;
        end
    end

    wire sel_rise;
    wire sel_fall;

    assign sel_rise = sel_s & ~sel_d_r;
    assign sel_fall = ~sel_s & sel_d_r;

    reg [`LTMC_ST_W-1:0] state_r;
    reg [`LTMC_ST_W-1:0] state_nxt;

    wire in_por;
    wire in_ready;
    wire in_oper;
    wire in_txoff;
    wire in_pdown;

    assign in_por   = (state_r == `LTMC_ST_POR);
    assign in_ready = (state_r == `LTMC_ST_READY);
    assign in_oper  = (state_r == `LTMC_ST_OPER);
    assign in_txoff = (state_r == `LTMC_ST_TXOFF);
    assign in_pdown = (state_r == `LTMC_ST_PDOWN);

    // ------------------------------------------------------------
    // timers
    // ------------------------------------------------------------
    wire stab_run;
    wire stab_done;
    wire pd_run;
    wire pd_done;
    wire wf_run;
    wire wf_done;
    wire dom_run;
    wire dom_to;

    // regulator settle time restarts whenever the good flag drops
    assign stab_run = (in_ready | in_oper | in_txoff) & rgood_s;

    ltmc_tmr #(
        .W     (`LTMC_CNT_W),
        .LIMIT (STAB_MIN_CYC)
    ) u_stab (
        .clk_sys_i (clk_sys_i),
        .rst_i     (rst_i),
        .run_i     (stab_run),
        .done_o    (stab_done)
    );

    // both inputs must stay low for the deglitch time
    assign pd_run = in_txoff & ~sel_s & ~txd_s;

    ltmc_tmr #(
        .W     (`LTMC_CNT_W),
        .LIMIT (DEGLITCH_CYC)
    ) u_pdown (
        .clk_sys_i (clk_sys_i),
        .rst_i     (rst_i),
        .run_i     (pd_run),
        .done_o    (pd_done)
    );

    // wake threshold only used in power-down
    assign wf_run = in_pdown & wlow_s;

    ltmc_tmr #(
        .W     (`LTMC_CNT_W),
        .LIMIT (WAKE_FILT_CYC)
    ) u_wake (
        .clk_sys_i (clk_sys_i),
        .rst_i     (rst_i),
        .run_i     (wf_run),
        .done_o    (wf_done)
    );

    // dominant timer: bus low or our own transmitter stuck dominant; cleared in reset state
    assign dom_run = ~in_por & ~in_pdown & (~bus_s | (tx_en_o & ~txd_s));

    ltmc_tmr #(
        .W     (`LTMC_CNT_W),
        .LIMIT (DOM_TO_CYC)
    ) u_dom (
        .clk_sys_i (clk_sys_i),
        .rst_i     (rst_i),
        .run_i     (dom_run),
        .done_o    (dom_to)
    );

    // ------------------------------------------------------------
    // remote wake: filtered low phase armed, then a rise fires
    // ------------------------------------------------------------
    reg  wake_armed_r;
    wire bus_wake;

    always @(posedge clk_sys_i or posedge rst_i) begin
        if (rst_i) begin
            wake_armed_r <= 1'b0;
        end else if (!in_pdown) begin
            wake_armed_r <= 1'b0;
        end else if (wf_done) begin
            wake_armed_r <= 1'b1;
        end
    end

    assign bus_wake = wake_armed_r & wlow_d_r & ~wlow_s;

    // ------------------------------------------------------------
    // faults and regulator status
    // ------------------------------------------------------------
    wire fault;
    wire reg_ok;

    assign fault  = dom_to | short_s | therm_s | ~rgood_s;
    assign reg_ok = rgood_s & stab_done;

    // ------------------------------------------------------------
    // mode sequencer
    // ------------------------------------------------------------
    always @* begin
        state_nxt = state_r;
        if (off_s) begin
            state_nxt = `LTMC_ST_POR;
        end else begin
            case (state_r)
                `LTMC_ST_POR: begin
                    if (on_s) begin
                        state_nxt = `LTMC_ST_READY;
                    end
                end
                `LTMC_ST_READY: begin
                    if (reg_ok & sel_s) begin
                        if (txd_s) begin
                            state_nxt = `LTMC_ST_OPER;
                        end else begin
                            state_nxt = `LTMC_ST_TXOFF;
                        end
                    end
                end
                `LTMC_ST_OPER: begin
                    if (sel_fall | fault) begin
                        state_nxt = `LTMC_ST_TXOFF;
                    end
                end
                `LTMC_ST_TXOFF: begin
                    if (pd_done) begin
                        state_nxt = `LTMC_ST_PDOWN;
                    end else if (sel_rise & reg_ok & txd_s) begin
                        state_nxt = `LTMC_ST_OPER;
                    end
                end
                `LTMC_ST_PDOWN: begin
                    if (bus_wake | sel_s) begin
                        state_nxt = `LTMC_ST_READY;
                    end
                end
                default: begin
                    state_nxt = `LTMC_ST_POR;
                end
            endcase
        end
    end

    always @(posedge clk_sys_i or posedge rst_i) begin
        if (rst_i) begin
            state_r <= `LTMC_ST_POR;
        end else begin
            state_r <= state_nxt;
        end
    end

    // ------------------------------------------------------------
    // output decode, from the next state so outputs track the mode
    // ------------------------------------------------------------
    wire nxt_por;
    wire nxt_oper;
    wire nxt_pdown;
    wire nxt_reg_on;
    wire tx_allow;
    wire tx_nxt;

    assign nxt_por    = (state_nxt == `LTMC_ST_POR);
    assign nxt_oper   = (state_nxt == `LTMC_ST_OPER);
    assign nxt_pdown  = (state_nxt == `LTMC_ST_PDOWN);
    assign nxt_reg_on = ~nxt_por & ~nxt_pdown;

    // regulator doubt or a timeout keeps the bus quiet even in operation
    assign tx_allow = reg_ok & ~dom_to & ~therm_s;
    assign tx_nxt   = nxt_oper & tx_allow;

    always @(posedge clk_sys_i or posedge rst_i) begin
        if (rst_i) begin
            logic_rst_o     <= 1'b1;
            reg_en_o        <= 1'b0;
            reg_low_power_o <= 1'b0;
            rx_en_o         <= 1'b0;
            wake_en_o       <= 1'b0;
            state_o         <= `LTMC_ST_POR;
        end else begin
            logic_rst_o     <= nxt_por;
            reg_en_o        <= nxt_reg_on;
            reg_low_power_o <= nxt_reg_on & ~nxt_oper;
            rx_en_o         <= nxt_reg_on;
            wake_en_o       <= nxt_pdown;
            state_o         <= state_nxt;
        end
    end

    // transmitter and pull-up
    always @(posedge clk_sys_i or posedge rst_i) begin
        if (rst_i) begin
            tx_en_o     <= 1'b0;
            pullup_en_o <= 1'b0;
        end else begin
            tx_en_o     <= tx_nxt;
            pullup_en_o <= nxt_oper & ~dom_to;
        end
    end

    // open-drain bus: pulled low only for a dominant bit
    always @(posedge clk_sys_i or posedge rst_i) begin
        if (rst_i) begin
            bus_line_o      <= 1'b0;
            bus_line_oe_n_o <= 1'b1;
        end else begin
            bus_line_o      <= 1'b0;
            bus_line_oe_n_o <= ~(tx_nxt & ~txd_s);
        end
    end

    // receive path idles recessive whenever the receiver is off
    always @(posedge clk_sys_i or posedge rst_i) begin
        if (rst_i) begin
            rxd_o <= 1'b1;
        end else if (!nxt_reg_on || dom_to) begin
            rxd_o <= 1'b1;
        end else begin
            rxd_o <= bus_s;
        end
    end

    // reset pin: released only with the regulator on and good
    always @(posedge clk_sys_i or posedge rst_i) begin
        if (rst_i) begin
            reset_o      <= 1'b0;
            reset_oe_n_o <= 1'b0;
        end else begin
            reset_o      <= 1'b0;
            reset_oe_n_o <= nxt_reg_on & rgood_s;
        end
    end

endmodule

// ==== tb/ltmc_ctrl_properties.sv ====
`include "ltmc_defs.vh"

module ltmc_ctrl_properties #(
    parameter [`LTMC_CNT_W-1:0] DEGLITCH_CYC = `LTMC_DEGLITCH_CYC,
    parameter [`LTMC_CNT_W-1:0] STAB_MIN_CYC = `LTMC_STAB_MIN_CYC
) (
    input logic                  clk_sys_i,
    input logic                  rst_i,
    input logic                  supply_below_off_i,
    input logic                  regulator_good_i,
    input logic                  select_wake_input_i,
    input logic                  txd_i,
    input logic                  logic_rst_o,
    input logic                  tx_en_o,
    input logic                  rx_en_o,
    input logic                  reg_en_o,
    input logic                  reg_low_power_o,
    input logic                  pullup_en_o,
    input logic                  bus_line_oe_n_o,
    input logic                  reset_oe_n_o,
    input logic [`LTMC_ST_W-1:0] state_o
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge clk_sys_i); endclocking
    default disable iff (rst_i);

    logic [`LTMC_CNT_W-1:0] dwell_r;
    logic [`LTMC_ST_W-1:0]  prev_r;

    // cycles spent in the current mode, for the minimum-wait checks
    always @(posedge clk_sys_i or posedge rst_i) begin
        if (rst_i) begin
            dwell_r <= '0;
            prev_r  <= `LTMC_ST_POR;
        end else begin
            dwell_r <= (state_o == prev_r) ? dwell_r + 1'b1 : '0;
            prev_r  <= state_o;
        end
    end

    sequence s_low_supply;
        supply_below_off_i [*5];
    endsequence
    sequence s_sel_fall;
        (state_o == `LTMC_ST_OPER && $fell(select_wake_input_i)) ##1 !select_wake_input_i [*4];
    endsequence
    sequence s_leave_ready;
        $changed(state_o) && $past(state_o) == `LTMC_ST_READY && state_o != `LTMC_ST_POR;
    endsequence

    AST_POR_OUTS:
    assert property (state_o == `LTMC_ST_POR |-> logic_rst_o && !reset_oe_n_o && !tx_en_o
        && !rx_en_o && !reg_en_o) else $error("reset mode outputs wrong");
    AST_LOW_SUPPLY:
    assert property (s_low_supply |=> state_o == `LTMC_ST_POR) else $error("low supply ignored");
    AST_POR_EXIT:
    assert property ($changed(state_o) && $past(state_o) == `LTMC_ST_POR
        |-> state_o == `LTMC_ST_READY) else $error("reset mode left to wrong mode");
    AST_READY_OUTS:
    assert property (state_o == `LTMC_ST_READY |-> reg_en_o && reg_low_power_o && rx_en_o
        && !tx_en_o) else $error("ready mode outputs wrong");
    AST_OPER_ONLY:
    assert property ((tx_en_o || pullup_en_o) |-> state_o == `LTMC_ST_OPER)
        else $error("pull-up or transmitter outside operation");
    AST_SEL_FALL:
    assert property (s_sel_fall |=> state_o != `LTMC_ST_OPER) else $error("select fall ignored");
    AST_REG_BAD:
    assert property (!regulator_good_i [*5] |=> !tx_en_o && !reset_oe_n_o)
        else $error("transmitter or reset active with bad regulator");
    AST_PDOWN_ENTRY:
    assert property ($changed(state_o) && state_o == `LTMC_ST_PDOWN |-> $past(state_o)
        == `LTMC_ST_TXOFF && dwell_r >= DEGLITCH_CYC - 6) else $error("early power-down");
    AST_WAKE_SEL:
    assert property (state_o == `LTMC_ST_PDOWN && select_wake_input_i
        |-> ##[1:6] state_o != `LTMC_ST_PDOWN) else $error("select wake too slow");
    AST_STAB_WAIT:
    assert property (s_leave_ready |-> dwell_r >= STAB_MIN_CYC - 6)
        else $error("ready left before regulator settled");
    AST_BUS_DRIVE:
    assert property ((tx_en_o && !txd_i) [*6] |-> !bus_line_oe_n_o)
        else $error("bus not driven dominant");
endmodule

bind ltmc_ctrl ltmc_ctrl_properties #(
    .DEGLITCH_CYC(DEGLITCH_CYC),
    .STAB_MIN_CYC(STAB_MIN_CYC)
) u_props (
    .clk_sys_i(clk_sys_i), .rst_i(rst_i), .supply_below_off_i(supply_below_off_i),
    .regulator_good_i(regulator_good_i), .select_wake_input_i(select_wake_input_i),
    .txd_i(txd_i), .logic_rst_o(logic_rst_o), .tx_en_o(tx_en_o), .rx_en_o(rx_en_o),
    .reg_en_o(reg_en_o), .reg_low_power_o(reg_low_power_o), .pullup_en_o(pullup_en_o),
    .bus_line_oe_n_o(bus_line_oe_n_o), .reset_oe_n_o(reset_oe_n_o), .state_o(state_o)
);

// ==== tb/ltmc_host_model.sv ====
module ltmc_host_model (
    input  logic clk_sys_i,
    input  logic stall_i,
    input  logic sel_req_i,
    input  logic txd_req_i,
    output logic select_wake_input_o,
    output logic txd_o
);
    timeunit 1ns;
    timeprecision 1ps;
    initial begin
        select_wake_input_o = 1'b0;
        txd_o = 1'b1;
    end
    // a stalled host freezes its pins, like a slow firmware loop
    always @(negedge clk_sys_i) begin
        if (!stall_i) begin
            txd_o <= txd_req_i;
            // transmit line settles first, select only moves once it has
            if (txd_o == txd_req_i) begin
                select_wake_input_o <= sel_req_i;
            end
        end
    end
endmodule

// ==== tb/lin_transceiver_mode_controller_test.sv ====
`include "ltmc_defs.vh"

module lin_transceiver_mode_controller_test;
    timeunit 1ns;
    timeprecision 1ps;
    // shortened counts keep the run brief
    localparam logic [23:0] DEG = 24'h14;
    localparam logic [23:0] WFL = 24'h1E;
    localparam logic [23:0] STB = 24'h28;
    localparam logic [23:0] DOM = 24'h64;
    logic clk_sys_i = 1'b0;
    logic rst_i = 1'b1;
    logic above_on = 1'b0, below_off = 1'b1, good = 1'b0, therm = 1'b0, short_f = 1'b0;
    logic wake_low = 1'b0, stall = 1'b0, sel_req = 1'b0, txd_req = 1'b1;
    logic sel, txd, lrst, tx_en, rx_en, reg_en, reg_lp, pu_en, wake_en, oe_n, rxd, rel;
    logic bus_drv, rst_drv;
    logic [`LTMC_ST_W-1:0] state;
    int mismatches = 0, checks_done = 0, m_st;
    logic q_bits[$];

    always #2 clk_sys_i = ~clk_sys_i;

    ltmc_host_model host_m (.clk_sys_i(clk_sys_i), .stall_i(stall), .sel_req_i(sel_req),
        .txd_req_i(txd_req), .select_wake_input_o(sel), .txd_o(txd));

    // lone node on the bus: its level is our own open-drain pull
    ltmc_ctrl #(.DEGLITCH_CYC(DEG), .WAKE_FILT_CYC(WFL), .STAB_MIN_CYC(STB),
        .DOM_TO_CYC(DOM)) dut (
        .clk_sys_i(clk_sys_i), .rst_i(rst_i), .supply_above_on_i(above_on),
        .supply_below_off_i(below_off), .regulator_good_i(good), .thermal_fault_i(therm),
        .bus_short_fault_i(short_f), .select_wake_input_i(sel), .txd_i(txd),
        .bus_line_i(oe_n), .bus_wake_low_i(wake_low), .logic_rst_o(lrst), .tx_en_o(tx_en),
        .rx_en_o(rx_en), .reg_en_o(reg_en), .reg_low_power_o(reg_lp), .pullup_en_o(pu_en),
        .wake_en_o(wake_en), .bus_line_o(bus_drv), .bus_line_oe_n_o(oe_n), .rxd_o(rxd),
        .reset_o(rst_drv), .reset_oe_n_o(rel), .state_o(state));

    // {logic reset, tx, rx, regulator, low power, pull-up, wake, reset released}
    function automatic logic [7:0] exp_o(input int st);
        case (st)
            `LTMC_ST_POR:   exp_o = 8'h80;
            `LTMC_ST_OPER:  exp_o = 8'h75;
            `LTMC_ST_PDOWN: exp_o = 8'h02;
            default:        exp_o = 8'h39;
        endcase
    endfunction

    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        checks_done++;
        if (seen !== exp) begin
            mismatches++;
            $display("mismatch at %0t: seen %0h expected %0h", $time, seen, exp);
        end
    endtask

    // wait a bounded time for the mode, let it settle, compare with the model
    task automatic go(input int st, input bit outs);
        int n;
        n = 0;
        m_st = st;
        while (state !== m_st[2:0] && n < 500) begin
            @(negedge clk_sys_i);
            n++;
        end
        repeat (4) @(negedge clk_sys_i);
        chk(8'(state), 8'(m_st));
        if (outs) chk({lrst, tx_en, rx_en, reg_en, reg_lp, pu_en, wake_en, rel}, exp_o(m_st));
    endtask

    task automatic stay(input int n);
        repeat (n) @(negedge clk_sys_i);
        chk(8'(state), 8'(m_st));
    endtask

    task automatic host(input logic s, input logic t);
        sel_req = s;
        txd_req = t;
        stall = 1'($urandom);
        repeat (2) @(negedge clk_sys_i);
        stall = 1'b0;
    endtask

    // select dropped with txd high, then raised again
    task automatic rejoin();
        host(1'b0, 1'b1);
        // long enough for the settle timer to finish after a good-flag drop
        stay(DEG + STB);
        host(1'b1, 1'b1);
        go(`LTMC_ST_OPER, 1);
    endtask

    task automatic finish_test();
        $display("checks %0d mismatches %0d", checks_done, mismatches);
        if (mismatches == 0 && checks_done > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask

    initial begin
        repeat (20000) @(posedge clk_sys_i);
        mismatches++;
        finish_test();
    end

    initial begin
        void'($urandom(32'h1c79));
        repeat (3) @(negedge clk_sys_i);
        rst_i = 1'b0;
        go(`LTMC_ST_POR, 1);
        above_on = 1'b1;
        stay(20);
        below_off = 1'b0;
        good = 1'b1;
        go(`LTMC_ST_READY, 1);
        host(1'b1, 1'b1);
        stay(STB / 2);
        go(`LTMC_ST_OPER, 1);
        repeat (8) q_bits.push_back(1'($urandom));
        while (q_bits.size() > 0) begin
            txd_req = q_bits[0];
            repeat (10) @(negedge clk_sys_i);
            chk(oe_n, q_bits[0]);
            chk(rxd, q_bits.pop_front());
            chk({bus_drv, rst_drv}, 8'h00);
        end
        txd_req = 1'b0;
        repeat (DOM + 20) @(negedge clk_sys_i);
        chk({tx_en, pu_en, rxd}, 3'b001);
        go(`LTMC_ST_TXOFF, 0);
        txd_req = 1'b1;
        rejoin();
        for (int f = 0; f < 3; f++) begin
            {good, short_f, therm} = (f == 0) ? 3'b101 : (f == 1) ? 3'b110 : 3'b000;
            go(`LTMC_ST_TXOFF, 0);
            {good, short_f, therm} = 3'b100;
            rejoin();
        end
        host(1'b0, 1'b0);
        go(`LTMC_ST_TXOFF, 1);
        go(`LTMC_ST_PDOWN, 1);
        host(1'b1, 1'b0);
        go(`LTMC_ST_READY, 1);
        go(`LTMC_ST_TXOFF, 1);
        host(1'b0, 1'b0);
        go(`LTMC_ST_PDOWN, 1);
        wake_low = 1'b1;
        repeat (WFL / 2) @(negedge clk_sys_i);
        wake_low = 1'b0;
        stay(20);
        wake_low = 1'b1;
        repeat (WFL + 10) @(negedge clk_sys_i);
        wake_low = 1'b0;
        go(`LTMC_ST_READY, 1);
        below_off = 1'b1;
        go(`LTMC_ST_POR, 1);
        finish_test();
    end
endmodule
